// [verilog/nsx_pkg.sv]
// Constants and carrier types for the nibble/xor/direction decode block
package nsx_pkg;
	// ------------------------------------------------------------
	// Opcode patterns
	// ------------------------------------------------------------
	localparam logic [11:0] NSX_NIBBLE_MASK = 12'hfc0;
	localparam logic [11:0] NSX_NIBBLE_CODE = 12'h380;
	localparam logic [11:0] NSX_RXOR_MASK = 12'hfc0;
	localparam logic [11:0] NSX_RXOR_CODE = 12'h180;
	localparam logic [11:0] NSX_DIR_MASK = 12'hff8;
	localparam logic [11:0] NSX_DIR_CODE = 12'h000;
	localparam logic [11:0] NSX_LXOR_MASK = 12'hf00;
	localparam logic [11:0] NSX_LXOR_CODE = 12'hf00;
	// ------------------------------------------------------------
	// Field positions and values
	// ------------------------------------------------------------
	localparam int NSX_DEST_BIT = 5;
	localparam logic [2:0] NSX_DIR_FIRST = 3'h5;
	localparam logic [7:0] NSX_W_RESET = 8'h00;
	localparam logic NSX_Z_RESET = 1'b0;

	typedef enum {NSX_IDLE, NSX_EXEC} nsx_state_t;

	// Request toward the file register and direction latches
	typedef struct packed {
		logic file_we;
		logic [4:0] file_addr;
		logic [7:0] file_wdata;
		logic dir_we;
		logic [2:0] dir_sel;
		logic [7:0] dir_wdata;
	} nsx_wr_t;

	typedef struct packed {
		logic w_we;
		logic z_we;
		logic file_we;
		logic dir_we;
		logic [7:0] result;
	} nsx_dec_t;
endpackage : nsx_pkg

// [verilog/nsx_alu.sv]
// Combinational decode and result of the four operations
`timescale 1ns/1ps
module nsx_alu (
	input wire logic [11:0] instr,
	input wire logic [7:0] w_val,
	input wire logic [7:0] file_val,
	output nsx_pkg::nsx_dec_t dec
);
	function automatic logic hit(input logic [11:0] i, input logic [11:0] m,
		input logic [11:0] c);
		hit = (i & m) == c;
	endfunction : hit

	always_comb begin
		dec = '0;
		if (hit(instr, nsx_pkg::NSX_NIBBLE_MASK, nsx_pkg::NSX_NIBBLE_CODE)) begin
			dec.result = {file_val[3:0], file_val[7:4]};
			dec.file_we = instr[nsx_pkg::NSX_DEST_BIT];
			dec.w_we = ~instr[nsx_pkg::NSX_DEST_BIT];
		end else if (hit(instr, nsx_pkg::NSX_RXOR_MASK, nsx_pkg::NSX_RXOR_CODE)) begin
			dec.result = w_val ^ file_val;
			dec.z_we = 1'b1;
			dec.file_we = instr[nsx_pkg::NSX_DEST_BIT];
			dec.w_we = ~instr[nsx_pkg::NSX_DEST_BIT];
		end else if (hit(instr, nsx_pkg::NSX_LXOR_MASK, nsx_pkg::NSX_LXOR_CODE)) begin
			dec.result = w_val ^ instr[7:0];
			dec.z_we = 1'b1;
			dec.w_we = 1'b1;
		end else if (hit(instr, nsx_pkg::NSX_DIR_MASK, nsx_pkg::NSX_DIR_CODE)) begin
			// Selections below 5 are other opcodes sharing this row; ignore them
			dec.result = w_val;
			dec.dir_we = instr[2:0] >= nsx_pkg::NSX_DIR_FIRST;
		end
	end
endmodule : nsx_alu

// [verilog/nsx_core.sv]
// Execute stage: working register, zero flag and write requests
`timescale 1ns/1ps
module nsx_core (
	input wire logic clk,
	input wire logic reset,
	input wire logic instr_valid,
	input wire logic [11:0] instr,
	input wire logic [7:0] file_rdata,
	output logic [4:0] file_raddr,
	output nsx_pkg::nsx_wr_t wr,
	output logic [7:0] w_out,
	output logic z_out,
	output logic done
);
	nsx_pkg::nsx_dec_t dec;
	logic [7:0] w_reg, w_next;
	logic z_reg, z_next;
	nsx_pkg::nsx_wr_t wr_reg, wr_next;
	logic done_reg, done_next;

	// ------------------------------------------------------------
	// Decode
	// ------------------------------------------------------------
	// File read is combinational so every operation ends in one cycle
	assign file_raddr = instr[4:0];

	nsx_alu u_alu (
		.instr(instr),
		.w_val(w_reg),
		.file_val(file_rdata),
		.dec(dec)
	);

	// ------------------------------------------------------------
	// Execute
	// ------------------------------------------------------------
	always_comb begin
		w_next = w_reg;
		z_next = z_reg;
		wr_next = '0;
		done_next = instr_valid;
		if (instr_valid) begin
			if (dec.w_we) begin
				w_next = dec.result;
			end
			if (dec.z_we) begin
				z_next = dec.result == 8'h00;
			end
			wr_next.file_we = dec.file_we;
			wr_next.file_addr = instr[4:0];
			wr_next.file_wdata = dec.result;
			wr_next.dir_we = dec.dir_we;
			wr_next.dir_sel = instr[2:0];
			wr_next.dir_wdata = w_reg;
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			w_reg <= nsx_pkg::NSX_W_RESET;
			z_reg <= nsx_pkg::NSX_Z_RESET;
			wr_reg <= '0;
			done_reg <= 1'b0;
		end else begin
			w_reg <= w_next;
			z_reg <= z_next;
			wr_reg <= wr_next;
			done_reg <= done_next;
		end
	end

	assign wr = wr_reg;
	assign w_out = w_reg;
	assign z_out = z_reg;
	assign done = done_reg;

	// ------------------------------------------------------------
	// Opcode classes seen by the checks
	// ------------------------------------------------------------
	// Taken straight from the package patterns, apart from the decoder,
	// so a slip in the decoder's priority chain shows up as a failure
	logic is_swap, is_rxor, is_lxor, is_dir, is_dest_file;
	assign is_swap = (instr & nsx_pkg::NSX_NIBBLE_MASK) == nsx_pkg::NSX_NIBBLE_CODE;
	assign is_rxor = (instr & nsx_pkg::NSX_RXOR_MASK) == nsx_pkg::NSX_RXOR_CODE;
	assign is_lxor = (instr & nsx_pkg::NSX_LXOR_MASK) == nsx_pkg::NSX_LXOR_CODE;
	assign is_dir = (instr & nsx_pkg::NSX_DIR_MASK) == nsx_pkg::NSX_DIR_CODE;
	assign is_dest_file = instr[nsx_pkg::NSX_DEST_BIT];

	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------
	AST_SWAP_W: assert property (@(posedge clk) disable iff (reset)
		instr_valid && (instr & 12'hfe0) == 12'h380 |=>
		w_reg == {$past(file_rdata[3:0]), $past(file_rdata[7:4])} && $stable(z_reg))
		else $error("nibble exchange to w wrong");
	AST_SWAP_F: assert property (@(posedge clk) disable iff (reset)
		instr_valid && (instr & 12'hfe0) == 12'h3a0 |=>
		wr.file_we && wr.file_wdata == {$past(file_rdata[3:0]), $past(file_rdata[7:4])}
		&& $stable(w_reg))
		else $error("nibble exchange to file wrong");
	AST_DIR: assert property (@(posedge clk) disable iff (reset)
		instr_valid && (instr & 12'hff8) == 12'h000 |=>
		wr.dir_we == ($past(instr[2:0]) >= 3'h5) && $stable(z_reg) && $stable(w_reg))
		else $error("direction load wrong");
	AST_RXOR_Z: assert property (@(posedge clk) disable iff (reset)
		instr_valid && (instr & 12'hfc0) == 12'h180 |=>
		z_reg == (($past(w_reg) ^ $past(file_rdata)) == 8'h00))
		else $error("register xor zero flag wrong");
	AST_RXOR_D: assert property (@(posedge clk) disable iff (reset)
		instr_valid && (instr & 12'hfe0) == 12'h1a0 |=>
		wr.file_we && wr.file_wdata == ($past(w_reg) ^ $past(file_rdata)) && $stable(w_reg))
		else $error("register xor to file wrong");
	AST_RXOR_W: assert property (@(posedge clk) disable iff (reset)
		instr_valid && (instr & 12'hfe0) == 12'h180 |=>
		!wr.file_we && w_reg == ($past(w_reg) ^ $past(file_rdata)))
		else $error("register xor to w wrong");
	AST_LXOR: assert property (@(posedge clk) disable iff (reset)
		instr_valid && (instr & 12'hf00) == 12'hf00 |=>
		w_reg == ($past(w_reg) ^ $past(instr[7:0])) && z_reg == (w_reg == 8'h00))
		else $error("literal xor wrong");
	AST_IDLE: assert property (@(posedge clk) disable iff (reset)
		!instr_valid |=> $stable(w_reg) && !wr.file_we && !wr.dir_we && !done)
		else $error("state changed without instruction");

	// ------------------------------------------------------------
	// Checks on side effects and sources
	// ------------------------------------------------------------
	// Each request bit must trace back to one of the opcode classes allowed to raise it
	AST_DONE: assert property (@(posedge clk) disable iff (reset)
		instr_valid
		|=> done)
		else $error("done missing after instruction");

	AST_UNKNOWN: assert property (@(posedge clk) disable iff (reset)
		instr_valid && !is_swap && !is_rxor && !is_lxor && !is_dir
		|=> $stable(w_reg) && $stable(z_reg) && !wr.file_we && !wr.dir_we)
		else $error("unknown opcode changed state");

	AST_DIR_REFUSE: assert property (@(posedge clk) disable iff (reset)
		instr_valid && is_dir && instr[2:0] < nsx_pkg::NSX_DIR_FIRST
		|=> !wr.dir_we && !wr.file_we && $stable(w_reg) && $stable(z_reg))
		else $error("refused direction selection acted");

	AST_DIR_DATA: assert property (@(posedge clk) disable iff (reset)
		instr_valid && is_dir && instr[2:0] >= nsx_pkg::NSX_DIR_FIRST
		|=> wr.dir_sel == $past(instr[2:0]) && wr.dir_wdata == $past(w_reg)
		&& !wr.file_we)
		else $error("direction load data wrong");

	AST_SWAP_ADDR: assert property (@(posedge clk) disable iff (reset)
		instr_valid && is_swap && is_dest_file
		|=> wr.file_addr == $past(instr[4:0]) && !wr.dir_we)
		else $error("nibble exchange address wrong");

	AST_SWAP_Z: assert property (@(posedge clk) disable iff (reset)
		instr_valid && is_swap
		|=> $stable(z_reg) && !wr.dir_we)
		else $error("nibble exchange touched flags");

	AST_SWAP_KEEP: assert property (@(posedge clk) disable iff (reset)
		instr_valid && is_swap && !is_dest_file
		|=> !wr.file_we)
		else $error("nibble exchange to w wrote file");

	AST_RXOR_ADDR: assert property (@(posedge clk) disable iff (reset)
		instr_valid && is_rxor && is_dest_file
		|=> wr.file_addr == $past(instr[4:0]))
		else $error("register xor address wrong");

	AST_RXOR_NODIR: assert property (@(posedge clk) disable iff (reset)
		instr_valid && is_rxor
		|=> !wr.dir_we)
		else $error("register xor wrote direction latch");

	AST_LXOR_NOWR: assert property (@(posedge clk) disable iff (reset)
		instr_valid && is_lxor
		|=> !wr.file_we && !wr.dir_we)
		else $error("literal xor wrote outside w");

	AST_FILE_SRC: assert property (@(posedge clk) disable iff (reset)
		wr.file_we
		|-> $past(instr_valid && (is_swap || is_rxor) && is_dest_file))
		else $error("file write without source");

	AST_DIR_SRC: assert property (@(posedge clk) disable iff (reset)
		wr.dir_we
		|-> $past(instr_valid && is_dir && instr[2:0] >= nsx_pkg::NSX_DIR_FIRST))
		else $error("direction write without source");

	// Only the two xor forms may move the zero flag
	AST_Z_SRC: assert property (@(posedge clk) disable iff (reset)
		!$stable(z_reg)
		|-> $past(instr_valid && (is_rxor || is_lxor)))
		else $error("zero flag moved without xor");

	AST_W_SRC: assert property (@(posedge clk) disable iff (reset)
		!$stable(w_reg)
		|-> $past(instr_valid && (((is_swap || is_rxor) && !is_dest_file) || is_lxor)))
		else $error("working register moved without source");

	// ------------------------------------------------------------
	// Reset checks
	// ------------------------------------------------------------
	AST_RESET: assert property (@(posedge clk)
		reset
		|=> w_reg == nsx_pkg::NSX_W_RESET && z_reg == nsx_pkg::NSX_Z_RESET
		&& wr == '0 && !done)
		else $error("reset values wrong");
endmodule : nsx_core

// [tb/nsx_file_model.sv]
// File register and direction latch model at the far side of the decode block
`timescale 1ns/1ps
module nsx_file_model (
	input wire logic clk,
	input wire logic [4:0] raddr,
	input wire nsx_pkg::nsx_wr_t wr,
	output logic [7:0] rdata
);
	logic [7:0] mem [32];
	logic [7:0] dir [8];
	initial for (int i = 0; i < 32; i++) mem[i] = 8'(i * 37 + 11);
	// Read is combinational; a write lands one edge after the request shows
	assign rdata = mem[raddr];
	always @(posedge clk) begin
		if (wr.file_we) mem[wr.file_addr] <= wr.file_wdata;
		if (wr.dir_we) dir[wr.dir_sel] <= wr.dir_wdata;
	end
endmodule : nsx_file_model

// [tb/tb_nibble_swap_xor_dir_load_ops.sv]
// Self-checking bench for the nibble/xor/direction decode block
`timescale 1ns/1ps
module tb_nibble_swap_xor_dir_load_ops;
	logic clk, reset, instr_valid, z_out, done;
	logic [11:0] instr;
	logic [7:0] file_rdata, w_out;
	logic [4:0] file_raddr;
	nsx_pkg::nsx_wr_t wr;
	int error_cnt, samples_checked, cycles, w, z, e_done, e_fwe, e_fa, e_fd, e_dwe, e_ds, e_dd;
	int op, f, d, k, res, p_en, p_a, p_d;
	int mem[32];
	nsx_core i_nsx_core (.clk(clk), .reset(reset), .instr_valid(instr_valid), .instr(instr),
		.file_rdata(file_rdata), .file_raddr(file_raddr), .wr(wr), .w_out(w_out),
		.z_out(z_out), .done(done));
	nsx_file_model i_nsx_file_model (.clk(clk), .raddr(file_raddr), .wr(wr), .rdata(file_rdata));
	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end
	// Hang guard, far above the 600 cycles the run needs
	always @(posedge clk) begin
		cycles++;
		if (cycles > 2000) begin
			error_cnt++;
			finish_test();
		end
	end
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			error_cnt++;
			$display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : check
	task automatic finish_test();
		$display("errors %0d checks %0d", error_cnt, samples_checked);
		if (error_cnt == 0 && samples_checked > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask : finish_test
	// ------------------------------------------------------------
	// One instruction per falling edge, previous results checked first
	// ------------------------------------------------------------
	task automatic step();
		check(done, e_done);
		check(w_out, w);
		check(z_out, z);
		check(wr.file_we, e_fwe);
		if (e_fwe) check({wr.file_addr, wr.file_wdata}, e_fa * 256 + e_fd);
		check(wr.dir_we, e_dwe);
		if (e_dwe) check({wr.dir_sel, wr.dir_wdata}, e_ds * 256 + e_dd);
		op = $urandom % 6;
		f = $urandom % 32;
		d = $urandom % 2;
		k = (op == 3) ? w : $urandom % 256;
		e_done = 1;
		e_fwe = 0;
		e_dwe = 0;
		instr_valid = 1'b1;
		if (op < 2) begin
			instr = (op == 0 ? 12'h380 : 12'h180) | 12'(d * 32 + f);
			res = op == 0 ? (mem[f] % 16) * 16 + mem[f] / 16 : w ^ mem[f];
			if (op == 1) z = (res == 0);
			if (d == 1) begin
				e_fwe = 1;
				e_fa = f;
				e_fd = res;
			end else w = res;
		end else if (op < 4) begin
			instr = 12'hf00 | 12'(k);
			w = w ^ k;
			z = (w == 0);
		end else if (op == 4) begin
			instr = 12'(f % 8);
			e_dwe = (f % 8 >= 5);
			e_ds = f % 8;
			e_dd = w;
		end else begin
			instr_valid = 1'(d);
			instr = d ? (12'h040 | 12'(f)) : 12'($urandom);
			e_done = d;
		end
		// The far side commits a write one edge late, so the next read still sees old data
		if (p_en) mem[p_a] = p_d;
		p_en = e_fwe;
		p_a = e_fa;
		p_d = e_fd;
	endtask : step
	initial begin
		void'($urandom(55));
		for (int i = 0; i < 32; i++) mem[i] = (i * 37 + 11) % 256;
		reset = 1'b1;
		instr_valid = 1'b0;
		instr = 12'h000;
		repeat (4) @(posedge clk);
		@(negedge clk);
		reset = 1'b0;
		repeat (600) begin
			step();
			@(negedge clk);
		end
		finish_test();
	end
endmodule : tb_nibble_swap_xor_dir_load_ops
